// [wdim_watchdog.v]
`timescale 1ns/1ps
`include "wdim_defs.vh"
module wdim_watchdog #(
  parameter CNT_W = 21,
  parameter PULSE_CYC = `WDIM_RST_PULSE_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] config_byte_one,
  input wire rc_osc,
  input wire cpu_clk_tick,
  input wire other_reset,
  input wire power_down,
  input wire [7:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_write,
  input wire bus_read,
  output reg [7:0] bus_rdata,
  output reg wd_reset,
  output reg osc_restart,
  output reg interval_irq
);
  localparam [1:0] SETTLE_LAST = 2'h2;
  localparam [1:0] FEED_IDLE = 2'b01;
  localparam [1:0] FEED_ARMED = 2'b10;
  localparam [1:0] PULSE_IDLE = 2'b01;
  localparam [1:0] PULSE_ON = 2'b10;
  reg [7:0] watchdog_control;
  reg [7:0] next_control;
  reg [CNT_W-1:0] count;
  reg [CNT_W-1:0] next_count;
  reg [1:0] feed_state;
  reg [1:0] next_feed_state;
  reg written_once;
  reg next_written_once;
  reg [1:0] settle_cnt;
  reg [1:0] next_settle_cnt;
  reg cfg_loaded;
  reg [1:0] pulse_state;
  reg [1:0] next_pulse_state;
  reg [7:0] pulse_cnt;
  reg [7:0] next_pulse_cnt;
  reg next_osc_restart;
  reg next_irq;
  reg [7:0] next_rdata;
  reg rc_s1, rc_s2, rc_s3;
  reg [2:0] div_cnt;
  reg [7:0] cfg_s1, cfg_s2;
  reg oth_s1, oth_s2;
  reg pd_s1, pd_s2;

  // integer constants widened to 32 bits, then cut on purpose
  wire [31:0] div_last_w = `WDIM_CPU_DIV - 1;
  wire [31:0] pulse_last_w = PULSE_CYC - 1;
  wire [31:0] base_clocks_w = `WDIM_BASE_CLOCKS;

  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  function [CNT_W-1:0] timeout_clocks;
    input [2:0] rate;
    input [CNT_W-1:0] base;
    begin
      timeout_clocks = base << rate;
    end
  endfunction

  function [7:0] cause_reset_value;
    input enabled;
    begin
      cause_reset_value = enabled ? `WDIM_RESET_EN : `WDIM_RESET_DIS;
    end
  endfunction

  // reads show run and clock select as forced, not as stored
  function [7:0] control_view;
    input [7:0] stored;
    input run;
    input clk_sel;
    begin
      control_view = {2'b00, stored[`WDIM_BIT_OVF], run, clk_sel, stored[2:0]};
    end
  endfunction

  wire wd_enable_cfg = cfg_s2[`WDIM_CFG_ENABLE_BIT];
  wire run_control = wd_enable_cfg | watchdog_control[`WDIM_BIT_RUN];
  wire clock_select = ~wd_enable_cfg & watchdog_control[`WDIM_BIT_CLK];
  wire [2:0] rate_select = watchdog_control[2:0];
  wire wr_ctl = bus_write && addr_hit(bus_addr, `WDIM_ADDR_CONTROL);
  wire wr_feed = bus_write && addr_hit(bus_addr, `WDIM_ADDR_FEED);
  wire rd_ctl = bus_read && addr_hit(bus_addr, `WDIM_ADDR_CONTROL);
  wire feed_armed = (feed_state == FEED_ARMED);
  // any feed byte other than the first or second disarms but touches no count
  wire feed_done = wr_feed && feed_armed && (bus_wdata == `WDIM_FEED_SECOND);
  wire rc_tick = rc_s2 & ~rc_s3;
  wire div_tick = cpu_clk_tick && (div_cnt == div_last_w[2:0]);
  wire tmr_tick = clock_select ? div_tick : rc_tick;
  wire [CNT_W-1:0] limit = timeout_clocks(rate_select, base_clocks_w[CNT_W-1:0]);
  wire hold = wd_enable_cfg & oth_s2;
  // nothing counts until the synchronised config byte has settled
  wire count_step = cfg_loaded && run_control && !hold && tmr_tick;
  wire expire = count_step && (count == limit - 1'b1);
  wire wd_strike = expire && wd_enable_cfg;
  wire ctl_write_ok = wr_ctl && !(wd_enable_cfg && written_once);

  // rc oscillator and pins are asynchronous to clk_sys
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
      cfg_s1 <= 8'hff;
      cfg_s2 <= 8'hff;
      oth_s1 <= 1'b0;
      oth_s2 <= 1'b0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
    end else if (clk_en) begin
      rc_s1 <= rc_osc;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
      cfg_s1 <= config_byte_one;
      cfg_s2 <= cfg_s1;
      oth_s1 <= other_reset;
      oth_s2 <= oth_s1;
      pd_s1 <= power_down;
      pd_s2 <= pd_s1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 3'h0;
    end else if (clk_en && cpu_clk_tick) begin
      div_cnt <= div_tick ? 3'h0 : div_cnt + 3'h1;
    end
  end

  always @* begin
    next_feed_state = feed_state;
    case (feed_state)
      FEED_IDLE: begin
        if (wr_feed && bus_wdata == `WDIM_FEED_FIRST) begin
          next_feed_state = FEED_ARMED;
        end
      end
      FEED_ARMED: begin
        // other bus traffic between the two bytes leaves the arm intact
        if (wr_feed && bus_wdata != `WDIM_FEED_FIRST) begin
          next_feed_state = FEED_IDLE;
        end
      end
      default: begin
        next_feed_state = FEED_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      feed_state <= FEED_IDLE;
    end else if (clk_en) begin
      feed_state <= next_feed_state;
    end
  end

  always @* begin
    next_settle_cnt = settle_cnt;
    if (settle_cnt != SETTLE_LAST) begin
      next_settle_cnt = settle_cnt + 2'h1;
    end
  end

  // config sync needs two edges; the cause-dependent reset value waits for it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      cfg_loaded <= 1'b0;
    end else if (clk_en) begin
      settle_cnt <= next_settle_cnt;
      cfg_loaded <= (settle_cnt == SETTLE_LAST);
    end
  end

  always @* begin
    next_count = count;
    if (feed_done || hold || expire) begin
      next_count = {CNT_W{1'b0}};
    end else if (count_step) begin
      next_count = count + 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      count <= next_count;
    end
  end

  // async reset can only load a constant, so the value that depends on
  // the enable bit is loaded by clock once the config byte has settled
  always @* begin
    next_control = watchdog_control;
    next_written_once = written_once;
    if (!cfg_loaded) begin
      if (settle_cnt == SETTLE_LAST) begin
        next_control = cause_reset_value(wd_enable_cfg);
      end
    end else if (oth_s2) begin
      next_control = cause_reset_value(wd_enable_cfg);
      next_written_once = 1'b0;
    end else if (wd_strike) begin
      next_control = `WDIM_RESET_WDT;
      next_written_once = 1'b0;
    end else begin
      if (ctl_write_ok) begin
        // flag and reserved bits are never taken from the bus
        next_control[4:0] = bus_wdata[4:0];
        next_written_once = 1'b1;
      end
      if (expire) begin
        // set wins over a feed landing in the same cycle
        next_control[`WDIM_BIT_OVF] = 1'b1;
      end else if (feed_done) begin
        next_control[`WDIM_BIT_OVF] = 1'b0;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_control <= `WDIM_RESET_DIS;
      written_once <= 1'b0;
    end else if (clk_en) begin
      watchdog_control <= next_control;
      written_once <= next_written_once;
    end
  end

  always @* begin
    next_pulse_state = pulse_state;
    next_pulse_cnt = pulse_cnt;
    next_osc_restart = osc_restart;
    case (pulse_state)
      PULSE_IDLE: begin
        if (wd_strike) begin
          next_pulse_state = PULSE_ON;
          next_pulse_cnt = pulse_last_w[7:0];
          next_osc_restart = pd_s2;
        end
      end
      PULSE_ON: begin
        if (pulse_cnt != 8'h00) begin
          next_pulse_cnt = pulse_cnt - 8'h01;
        end else begin
          next_pulse_state = PULSE_IDLE;
          next_osc_restart = 1'b0;
        end
      end
      default: begin
        next_pulse_state = PULSE_IDLE;
        next_pulse_cnt = 8'h00;
        next_osc_restart = 1'b0;
      end
    endcase
  end

  // pulse counted on clk_sys; a dead cpu oscillator is still caught
  // because the rc path feeds the counter
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_state <= PULSE_IDLE;
      pulse_cnt <= 8'h00;
      wd_reset <= 1'b0;
      osc_restart <= 1'b0;
    end else if (clk_en) begin
      pulse_state <= next_pulse_state;
      pulse_cnt <= next_pulse_cnt;
      wd_reset <= (next_pulse_state == PULSE_ON);
      osc_restart <= next_osc_restart;
    end
  end

  always @* begin
    next_irq = 1'b0;
    if (expire && !wd_enable_cfg) begin
      // interval mode wraps the count and signals instead of resetting
      next_irq = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interval_irq <= 1'b0;
    end else if (clk_en) begin
      interval_irq <= next_irq;
    end
  end

  always @* begin
    next_rdata = 8'h00;
    if (rd_ctl) begin
      next_rdata = control_view(watchdog_control, run_control, clock_select);
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      bus_rdata <= next_rdata;
    end
  end
endmodule // wdim_watchdog

// [wdim_defs.vh]
`ifndef WDIM_DEFS_VH
`define WDIM_DEFS_VH
`define WDIM_ADDR_CONTROL 8'ha7
`define WDIM_ADDR_FEED 8'ha6
`define WDIM_FEED_FIRST 8'h1e
`define WDIM_FEED_SECOND 8'he1
`define WDIM_BIT_OVF 5
`define WDIM_BIT_RUN 4
`define WDIM_BIT_CLK 3
`define WDIM_RESET_WDT 8'h30
`define WDIM_RESET_EN 8'h10
`define WDIM_RESET_DIS 8'h00
`define WDIM_BASE_CLOCKS 8192
`define WDIM_CPU_DIV 6
`define WDIM_CLK_MHZ 40
`define WDIM_RST_PULSE_NS 1000
`define WDIM_RST_PULSE_CYC ((`WDIM_RST_PULSE_NS * `WDIM_CLK_MHZ) / 1000)
`define WDIM_CFG_ENABLE_BIT 7
`endif

// [wdim_chk_assertions.sv]
`timescale 1ns/1ps
module wdim_chk #(parameter PULSE_CYC = 40) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] config_byte_one,
  input wire [7:0] bus_addr,
  input wire bus_read,
  input wire [7:0] bus_rdata,
  input wire wd_reset,
  input wire osc_restart,
  input wire interval_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] pcnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pcnt <= 8'h00;
    else pcnt <= wd_reset ? pcnt + 8'h01 : 8'h00;
  end
  // config passes two sync flops, so look three edges back
  sequence rd_en;
    bus_read && bus_addr == 8'ha7 && config_byte_one[7] && $past(config_byte_one[7], 3);
  endsequence
  chk_run_forced: assert property (rd_en |=> bus_rdata[4]) else $error("run not forced");
  chk_clk_forced: assert property (rd_en |=> !bus_rdata[3]) else $error("clk not forced");
  chk_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == 8'h00) else $error("rdata not idle");
  chk_pulse_len: assert property ($fell(wd_reset) |-> pcnt == PULSE_CYC) else $error("pulse length");
  chk_pulse_max: assert property (wd_reset |-> pcnt < PULSE_CYC) else $error("pulse too long");
  chk_restart_pulse: assert property (osc_restart |-> wd_reset) else $error("restart alone");
  chk_irq_single: assert property (interval_irq |=> !interval_irq) else $error("irq not pulse");
  chk_irq_mode: assert property (interval_irq |-> !$past(config_byte_one[7], 3)) else $error("irq enabled");
endmodule // wdim_chk
bind wdim_watchdog wdim_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk_sys, .rst_n, .config_byte_one, .bus_addr,
  .bus_read, .bus_rdata, .wd_reset, .osc_restart, .interval_irq);

// [wdim_watchdog_test.sv]
`timescale 1ns/1ps
module wdim_watchdog_test;
  reg clk_sys = 1'b0, rst_n = 1'b0, rc_osc = 1'b0, cpu_clk_tick = 1'b0, power_down = 1'b0, cpu_on = 1'b1;
  reg bus_write = 1'b0, bus_read = 1'b0, other_reset = 1'b0;
  reg [7:0] config_byte_one = 8'h80, bus_addr = 8'h00, bus_wdata = 8'h00;
  wire [7:0] bus_rdata;
  wire wd_reset, osc_restart, interval_irq;
  integer n_mismatch = 0, cmp_count = 0, n;
  wdim_watchdog DUT (.clk_sys, .rst_n, .clk_en(1'b1), .config_byte_one, .rc_osc, .cpu_clk_tick, .other_reset,
    .power_down, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata, .wd_reset, .osc_restart, .interval_irq);
  initial forever #12.5 clk_sys = ~clk_sys;
  // fast rc so a rate 0 timeout is 16384 cycles
  always @(posedge clk_sys) begin
    rc_osc <= ~rc_osc;
    cpu_clk_tick <= cpu_on & ~cpu_clk_tick;
  end
  task final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string what, input [7:0] exp, input [7:0] got);
    cmp_count++;
    if (exp !== got) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    {bus_addr, bus_wdata, bus_write} <= {a, d, 1'b1};
    @(posedge clk_sys);
    bus_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string what);
    {bus_addr, bus_read} <= {a, 1'b1};
    @(posedge clk_sys);
    bus_read <= 1'b0;
    @(negedge clk_sys);
    check(what, exp, bus_rdata);
    @(posedge clk_sys);
  endtask
  task rst(input [7:0] c);
    {rst_n, config_byte_one} <= {1'b0, c};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  task t_enabled;
    rst(8'h80);
    rd(8'ha7, 8'h10, "ctl_rst_en");
    wr(8'ha6, 8'h1e);
    rd(8'ha7, 8'h10, "mid_feed");
    wr(8'ha6, 8'he1);
    wr(8'ha7, 8'h08);
    wr(8'ha7, 8'h07);
    rd(8'ha7, 8'h10, "write_once");
    repeat (8000) @(posedge clk_sys);
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'h55);
    {cpu_on, power_down} <= 2'b01;
    n = 8010;
    while (wd_reset !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check("timeout", 8'h01, {7'h00, n > 16380 && n < 16400});
    check("osc_restart", 8'h01, {7'h00, osc_restart});
    n = 0;
    while (wd_reset && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    {cpu_on, power_down} <= 2'b10;
    rd(8'ha7, 8'h30, "ctl_after_wdt");
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    rd(8'ha7, 8'h10, "ovf_fed");
  endtask
  task t_hold;
    rst(8'h80);
    wr(8'ha7, 8'h00);
    other_reset <= 1'b1;
    n = 0;
    repeat (17000) begin
      @(negedge clk_sys);
      if (wd_reset !== 1'b0) n++;
    end
    @(posedge clk_sys);
    other_reset <= 1'b0;
    check("held", 8'h00, {7'h00, n != 0});
    repeat (3) @(posedge clk_sys);
    wr(8'ha7, 8'h01);
    rd(8'ha7, 8'h11, "ctl_after_other");
  endtask
  task t_interval;
    rst(8'h00);
    rd(8'ha7, 8'h00, "ctl_rst_dis");
    wr(8'ha7, 8'h10);
    n = 0;
    while (interval_irq !== 1'b1 && n < 17000) begin
      @(negedge clk_sys);
      n++;
    end
    check("irq_seen", 8'h01, {7'h00, interval_irq === 1'b1 && wd_reset === 1'b0});
    @(posedge clk_sys);
    rd(8'ha7, 8'h30, "ovf_interval");
    wr(8'ha7, 8'h00);
    n = 0;
    repeat (17000) begin
      @(negedge clk_sys);
      if (interval_irq !== 1'b0) n++;
    end
    check("stopped", 8'h00, {7'h00, n != 0});
  endtask
  initial begin
    #2250000;
    n_mismatch++;
    final_report;
  end
  initial begin
    t_enabled;
    t_hold;
    t_interval;
    final_report;
  end
endmodule // wdim_watchdog_test
